// ### src/vtpa_pkg.sv
// Constants, types and helpers shared by the voice target and talk arbiter
package vtpa_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SILENCE_TIME_S = 10;
    localparam int unsigned DISPLAY_TIME_S = 3;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned SILENCE_CYCLES = SILENCE_TIME_S * CLK_HZ;
    localparam int unsigned DISPLAY_CYCLES = DISPLAY_TIME_S * CLK_HZ;
    localparam int unsigned FLASH_CYCLES = FLASH_HALF_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned CNT_W = 32;

    // Widths
    localparam int unsigned SLOT_COUNT = 8;
    localparam int unsigned SLOT_IDX_W = 3;
    localparam int unsigned IDENT_W = 24;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned LEVEL_W = 4;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned VOL_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_VOLUME = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TARGET = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_SLOT_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] REG_SLOT_LAST = 8'h3C;
    localparam int unsigned SLOT_ADDR_LSB = 2;

    // Field positions
    localparam int unsigned CTRL_SDPRIO_BIT = 8;
    localparam int unsigned VOL_MIC_LSB = 8;
    localparam int unsigned TARGET_MASK_LSB = 8;
    localparam int unsigned STATUS_SUSPEND_BIT = 4;
    localparam int unsigned STATUS_SHOW_BIT = 5;

    // Reset values
    localparam logic [VOL_W-1:0] VOL_MEDIUM = 3'h3;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
    localparam logic [IDENT_W-1:0] IDENT_NONE = 24'h00_0000;

    typedef struct packed {
        logic sd_priority;
        logic [PRIO_W-1:0] call_priority;
    } vtpa_ctrl_t;

    typedef struct packed {
        logic [VOL_W-1:0] mic;
        logic [VOL_W-1:0] speaker;
    } vtpa_volume_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } vtpa_bus_t;

    typedef struct packed {
        logic talk;
        logic select;
        logic silence;
    } vtpa_pins_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_TALK, ST_INSERT} vtpa_state_t;

    // One LED segment per destination index
    function automatic logic [SLOT_COUNT-1:0] slot_onehot(input logic [SLOT_IDX_W-1:0] idx);
        logic [SLOT_COUNT-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // Next configured slot above idx, wrapping to the lowest; idx if none
    function automatic logic [SLOT_IDX_W-1:0] next_slot(input logic [SLOT_IDX_W-1:0] idx,
                                                       input logic [SLOT_COUNT-1:0] mask);
        logic [SLOT_IDX_W-1:0] cand;
        logic [SLOT_IDX_W-1:0] found;
        logic hit;
        found = idx;
        hit = 1'b0;
        for (int i = 1; i < SLOT_COUNT; i++) begin
            cand = idx + i[SLOT_IDX_W-1:0];
            if (!hit && mask[cand]) begin
                found = cand;
                hit = 1'b1;
            end
        end
        return found;
    endfunction
endpackage

// ### src/vtpa_slot_mem.sv
// Destination identity table with two registered read ports
module vtpa_slot_mem (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic wr_en,
    input wire logic [vtpa_pkg::SLOT_IDX_W-1:0] wr_idx,
    input wire logic [vtpa_pkg::IDENT_W-1:0] wr_data,
    input wire logic [vtpa_pkg::SLOT_IDX_W-1:0] rd_a_idx,
    input wire logic [vtpa_pkg::SLOT_IDX_W-1:0] rd_b_idx,
    output logic [vtpa_pkg::IDENT_W-1:0] rd_a_data,
    output logic [vtpa_pkg::IDENT_W-1:0] rd_b_data
);
    import vtpa_pkg::*;

    logic [IDENT_W-1:0] mem_reg [SLOT_COUNT];

    // Cleared at reset so an empty slot never shows stale identity
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < SLOT_COUNT; i++) begin
                mem_reg[i] <= IDENT_NONE;
            end
        end else if (wr_en) begin
            mem_reg[wr_idx] <= wr_data;
        end
    end

    // Registered read ports
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rd_a_data <= IDENT_NONE;
            rd_b_data <= IDENT_NONE;
        end else begin
            rd_a_data <= mem_reg[rd_a_idx];
            rd_b_data <= mem_reg[rd_b_idx];
        end
    end
endmodule

// ### src/vtpa_voice_arbiter.sv
// Talk/data arbiter with handset destination selection and LED bar display
// Notes on behaviour
// - Talk button press suspends data traffic on the radio link.
// - Once speech connection is up, play the talk-ready tone in the earphone.
// - Keep data suspended during speech; after 10 s silence re-establish link, resume.
// - Hold a table of eight destination identities, individual or group.
// - A target write or handset advance never selects a slot holding identity zero; reset leaves slot 0, holding zero, as the active target.
// - One configured call priority is applied to every outgoing call.
// - With short data priority on, pause transmitting voice to send message, with tones.
// - First select press flashes active index on LED bar, destination unchanged.
// - Show destination 3 s after last select press, then back to signal level.
// - Each further press within the window advances to the next slot.
// - Advancing skips slots with no configured identity.
// - Advanced destination takes effect at once for the next call.
// - During any voice call the active slot shows as an inverted flash.
// - Speaker and microphone volume start at medium level.
module vtpa_voice_arbiter #(
    parameter int unsigned SILENCE_CNT = vtpa_pkg::SILENCE_CYCLES,
    parameter int unsigned DISPLAY_CNT = vtpa_pkg::DISPLAY_CYCLES,
    parameter int unsigned FLASH_CNT = vtpa_pkg::FLASH_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire vtpa_pkg::vtpa_bus_t REG_BUS,
    output logic [vtpa_pkg::DATA_W-1:0] REG_RDATA,
    input wire vtpa_pkg::vtpa_pins_t HANDSET_PINS,
    input wire logic VOICE_LINK_UP,
    input wire logic MSG_PENDING,
    input wire logic MSG_DONE,
    input wire logic [vtpa_pkg::LEVEL_W-1:0] SIGNAL_STRENGTH_LEVEL,
    output logic DATA_SUSPEND,
    output logic LINK_REESTABLISH,
    output logic TONE_TALK_READY,
    output logic TONE_INTERRUPT,
    output logic VOICE_TX_PAUSE,
    output logic MSG_SEND,
    output logic [vtpa_pkg::PRIO_W-1:0] CALL_PRIORITY,
    output logic [vtpa_pkg::IDENT_W-1:0] CALL_TARGET,
    output vtpa_pkg::vtpa_volume_t VOLUME,
    output logic [vtpa_pkg::SLOT_COUNT-1:0] LED_BAR
);
    import vtpa_pkg::*;

    vtpa_pins_t sync1_reg;
    vtpa_pins_t sync2_reg;
    logic select_prev_reg;
    vtpa_state_t state_reg;
    vtpa_state_t state_next;
    vtpa_ctrl_t ctrl_reg;
    vtpa_volume_t volume_reg;
    logic [SLOT_COUNT-1:0] mask_reg;
    logic [SLOT_IDX_W-1:0] idx_reg;
    logic [SLOT_IDX_W-1:0] idx_next;
    logic show_reg;
    logic [CNT_W-1:0] disp_cnt_reg;
    logic [CNT_W-1:0] silence_cnt_reg;
    logic [CNT_W-1:0] flash_cnt_reg;
    logic blink_reg;
    logic [SLOT_COUNT-1:0] led_next;
    logic [DATA_W-1:0] rdata_reg;
    logic rd_slot_reg;
    logic [IDENT_W-1:0] mem_a_data;
    logic [IDENT_W-1:0] mem_b_data;

    // Handset pins come from outside the clock domain
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            select_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= HANDSET_PINS;
            sync2_reg <= sync1_reg;
            // Edge detect reads only the second stage, never the metastable first
            select_prev_reg <= sync2_reg.select;
        end
    end

    // Address decode
    wire talk_on = sync2_reg.talk;
    wire select_press = sync2_reg.select && !select_prev_reg;
    wire is_slot = (REG_BUS.addr >= REG_SLOT_BASE) && (REG_BUS.addr <= REG_SLOT_LAST) &&
                   (REG_BUS.addr[SLOT_ADDR_LSB-1:0] == '0);
    wire [ADDR_W-1:0] slot_off = REG_BUS.addr - REG_SLOT_BASE;
    wire [SLOT_IDX_W-1:0] slot_sel = slot_off[SLOT_ADDR_LSB +: SLOT_IDX_W];
    wire wr_ctrl = REG_BUS.wr && (REG_BUS.addr == REG_CTRL);
    wire wr_volume = REG_BUS.wr && (REG_BUS.addr == REG_VOLUME);
    wire wr_target = REG_BUS.wr && (REG_BUS.addr == REG_TARGET);
    wire wr_slot = REG_BUS.wr && is_slot;
    wire [SLOT_IDX_W-1:0] wr_target_idx = REG_BUS.wdata[SLOT_IDX_W-1:0];
    wire [IDENT_W-1:0] wr_ident = REG_BUS.wdata[IDENT_W-1:0];
    wire [SLOT_IDX_W-1:0] advance_idx = next_slot(idx_reg, mask_reg);
    wire silence_done = (silence_cnt_reg >= SILENCE_CNT[CNT_W-1:0] - 1'b1);
    wire disp_done = (disp_cnt_reg == '0);
    wire flash_wrap = (flash_cnt_reg >= FLASH_CNT[CNT_W-1:0] - 1'b1);

    vtpa_slot_mem u_slot_mem (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .wr_en(wr_slot),
        .wr_idx(slot_sel),
        .wr_data(wr_ident),
        .rd_a_idx(slot_sel),
        .rd_b_idx(idx_reg),
        .rd_a_data(mem_a_data),
        .rd_b_data(mem_b_data)
    );

    // Configuration registers; volume starts at medium
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= '{sd_priority: 1'b0, call_priority: PRIO_RESET};
            volume_reg <= '{mic: VOL_MEDIUM, speaker: VOL_MEDIUM};
            mask_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.call_priority <= REG_BUS.wdata[PRIO_W-1:0];
                ctrl_reg.sd_priority <= REG_BUS.wdata[CTRL_SDPRIO_BIT];
            end
            if (wr_volume) begin
                volume_reg.speaker <= REG_BUS.wdata[VOL_W-1:0];
                volume_reg.mic <= REG_BUS.wdata[VOL_MIC_LSB +: VOL_W];
            end
            if (wr_slot) begin
                mask_reg[slot_sel] <= (wr_ident != IDENT_NONE);
            end
        end
    end

    // Destination index: bus select or handset advance
    always_comb begin
        idx_next = idx_reg;
        if (wr_target && mask_reg[wr_target_idx]) begin
            idx_next = wr_target_idx;
        end else if (select_press && show_reg) begin
            idx_next = advance_idx;
        end
    end

    // Display window: first press shows, later presses restart it
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            idx_reg <= '0;
            show_reg <= 1'b0;
            disp_cnt_reg <= '0;
        end else begin
            idx_reg <= idx_next;
            if (select_press) begin
                show_reg <= 1'b1;
                disp_cnt_reg <= DISPLAY_CNT[CNT_W-1:0] - 1'b1;
            end else if (show_reg && disp_done) begin
                show_reg <= 1'b0;
            end else if (show_reg) begin
                disp_cnt_reg <= disp_cnt_reg - 1'b1;
            end
        end
    end

    // Talk/data state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (talk_on) begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (VOICE_LINK_UP) begin
                    state_next = ST_TALK;
                end
            end
            ST_TALK: begin
                if (ctrl_reg.sd_priority && MSG_PENDING && talk_on) begin
                    state_next = ST_INSERT;
                end else if (silence_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_INSERT: begin
                if (MSG_DONE) begin
                    state_next = ST_TALK;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Silence counting only runs in talk with no keying and no speech
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
            silence_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_TALK && !talk_on && sync2_reg.silence && !silence_done) begin
                silence_cnt_reg <= silence_cnt_reg + 1'b1;
            end else begin
                silence_cnt_reg <= '0;
            end
        end
    end

    // Outputs of the talk/data side, registered
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            DATA_SUSPEND <= 1'b0;
            LINK_REESTABLISH <= 1'b0;
            TONE_TALK_READY <= 1'b0;
            TONE_INTERRUPT <= 1'b0;
            VOICE_TX_PAUSE <= 1'b0;
            MSG_SEND <= 1'b0;
        end else begin
            DATA_SUSPEND <= (state_next != ST_IDLE);
            LINK_REESTABLISH <= (state_reg == ST_TALK) && (state_next == ST_IDLE);
            TONE_TALK_READY <= (state_reg == ST_SETUP) && (state_next == ST_TALK);
            TONE_INTERRUPT <= (state_next == ST_INSERT);
            VOICE_TX_PAUSE <= (state_next == ST_INSERT);
            MSG_SEND <= (state_reg == ST_TALK) && (state_next == ST_INSERT);
        end
    end

    // Flash divider, a slow enable derived from the one clock
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            flash_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (flash_wrap) begin
            flash_cnt_reg <= '0;
            blink_reg <= !blink_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 1'b1;
        end
    end

    // LED bar: call marking wins over selection, selection over signal level
    always_comb begin
        led_next = '0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            led_next[i] = (SIGNAL_STRENGTH_LEVEL > i[LEVEL_W-1:0]);
        end
        if (state_reg != ST_IDLE) begin
            led_next = ~(slot_onehot(idx_reg) & {SLOT_COUNT{blink_reg}});
        end else if (show_reg) begin
            led_next = slot_onehot(idx_reg) & {SLOT_COUNT{blink_reg}};
        end
    end

    // Register read; slot words come out of the table a cycle later
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            LED_BAR <= '0;
            rdata_reg <= '0;
            rd_slot_reg <= 1'b0;
        end else begin
            LED_BAR <= led_next;
            rd_slot_reg <= REG_BUS.rd && is_slot;
            rdata_reg <= '0;
            if (REG_BUS.rd) begin
                if (REG_BUS.addr == REG_CTRL) begin
                    rdata_reg[PRIO_W-1:0] <= ctrl_reg.call_priority;
                    rdata_reg[CTRL_SDPRIO_BIT] <= ctrl_reg.sd_priority;
                end else if (REG_BUS.addr == REG_VOLUME) begin
                    rdata_reg[VOL_W-1:0] <= volume_reg.speaker;
                    rdata_reg[VOL_MIC_LSB +: VOL_W] <= volume_reg.mic;
                end else if (REG_BUS.addr == REG_TARGET) begin
                    rdata_reg[SLOT_IDX_W-1:0] <= idx_reg;
                    rdata_reg[TARGET_MASK_LSB +: SLOT_COUNT] <= mask_reg;
                end else if (REG_BUS.addr == REG_STATUS) begin
                    rdata_reg[$bits(vtpa_state_t)-1:0] <= state_reg;
                    rdata_reg[STATUS_SUSPEND_BIT] <= DATA_SUSPEND;
                    rdata_reg[STATUS_SHOW_BIT] <= show_reg;
                end
            end
        end
    end

    assign CALL_PRIORITY = ctrl_reg.call_priority;
    assign CALL_TARGET = mem_b_data;
    assign VOLUME = volume_reg;
    assign REG_RDATA = rd_slot_reg ? {{(DATA_W-IDENT_W){1'b0}}, mem_a_data} : rdata_reg;

    // Checks sleep in reset; counts follow the parameters, so short bench values work too
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    chk_talk_suspends: assert property ((state_reg == ST_IDLE) && talk_on |=> DATA_SUSPEND)
        else $error("talk press did not suspend data");
    chk_ready_tone: assert property ((state_reg == ST_SETUP) && VOICE_LINK_UP |=> TONE_TALK_READY ##1 !TONE_TALK_READY)
        else $error("talk ready tone missing or too long");
    chk_resume_after_silence: assert property (LINK_REESTABLISH |-> !DATA_SUSPEND && $past(silence_done))
        else $error("link resumed without full silence");
    chk_suspend_held: assert property ((state_reg != ST_IDLE) |-> DATA_SUSPEND)
        else $error("data resumed during speech");
    chk_zero_refused: assert property (wr_target && !mask_reg[wr_target_idx] && !select_press |=> $stable(idx_reg))
        else $error("empty slot became active");
    chk_insert_tones: assert property (MSG_SEND |-> TONE_INTERRUPT && VOICE_TX_PAUSE && ctrl_reg.sd_priority)
        else $error("message insert without pause and tone");
    chk_first_press_keeps: assert property (select_press && !show_reg && !wr_target |=> show_reg && $stable(idx_reg))
        else $error("first select press changed destination");
    chk_window_ends: assert property (show_reg && disp_done && !select_press |=> !show_reg)
        else $error("display window did not close");
    chk_advance_wraps: assert property (select_press && show_reg && !wr_target |=> idx_reg == $past(advance_idx))
        else $error("select press did not advance");
    chk_skip_empty: assert property ($changed(idx_reg) |-> mask_reg[idx_reg])
        else $error("advanced onto unconfigured slot");
    chk_call_inverted: assert property ((state_reg != ST_IDLE) && !blink_reg |=> LED_BAR == {SLOT_COUNT{1'b1}})
        else $error("call marking not inverted");
    chk_volume_medium: assert property (@(posedge CLOCK) $rose(RST_B) |-> VOLUME.mic == VOL_MEDIUM && VOLUME.speaker == VOL_MEDIUM)
        else $error("volume not medium after reset");
    chk_insert_refused: assert property ((state_reg == ST_TALK) && !(ctrl_reg.sd_priority && talk_on) |=> !MSG_SEND)
        else $error("message inserted without priority or keying");
    chk_resume_pulse: assert property (LINK_REESTABLISH |=> !LINK_REESTABLISH)
        else $error("link re-establish pulse too long");

    // Main scenarios a full run should reach
    cov_call_resumed: cover property (LINK_REESTABLISH);
    cov_first_press: cover property (select_press && !show_reg);
    cov_message_insert: cover property (MSG_SEND);
    cov_advance: cover property (select_press && show_reg && $changed(advance_idx));
    cov_window_closed: cover property ($fell(show_reg));
endmodule

// ### dv/vtpa_handset_model.sv
// Operator handset model: talk button, select button and audio silence detector
module vtpa_handset_model #(
    parameter int unsigned HOLD_CYCLES = 6
) (
    input wire logic clock,
    input wire logic talk_cmd,
    input wire logic silence_cmd,
    output vtpa_pkg::vtpa_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import vtpa_pkg::*;

    logic select_reg = 1'b0;

    // Buttons released at power up, so nothing reaches the synchroniser early
    initial pins = '0;

    // Pins move just after an edge, like a slow human contact
    always @(posedge clock) begin
        pins.talk <= talk_cmd;
        pins.silence <= silence_cmd;
        pins.select <= select_reg;
    end

    // One press, held long enough to pass a two-flop synchroniser, then a release gap
    task automatic press_select();
        select_reg <= 1'b1;
        repeat (HOLD_CYCLES) @(posedge clock);
        select_reg <= 1'b0;
        repeat (HOLD_CYCLES) @(posedge clock);
    endtask
endmodule

// ### dv/tb_voice_target_and_ptt_arbiter.sv
// Self-checking bench for the voice target and talk arbiter
module tb_voice_target_and_ptt_arbiter;
    timeunit 1ns;
    timeprecision 1ps;
    import vtpa_pkg::*;

    // Short counts keep the run small; expectations derive from these
    localparam int unsigned SIL = 200;
    localparam int unsigned DISP = 100;
    localparam int unsigned FLASH = 4;

    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    vtpa_bus_t bus = '0;
    vtpa_pins_t pins;
    logic talk_cmd = 1'b0;
    logic silence_cmd = 1'b0;
    logic link_up = 1'b0;
    logic msg_pending = 1'b0;
    logic msg_done = 1'b0;
    logic [LEVEL_W-1:0] level = 4'h3;
    logic [DATA_W-1:0] rdata;
    logic suspend, reestablish, tone_ready, tone_int, tx_pause, msg_send;
    logic [PRIO_W-1:0] prio;
    logic [IDENT_W-1:0] target;
    vtpa_volume_t volume;
    logic [SLOT_COUNT-1:0] leds;
    logic [IDENT_W-1:0] ids [SLOT_COUNT];
    logic [SLOT_IDX_W-1:0] walk [3];
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    vtpa_voice_arbiter #(.SILENCE_CNT(SIL), .DISPLAY_CNT(DISP), .FLASH_CNT(FLASH)) DUT (
        .CLOCK(CLOCK), .RST_B(RST_B), .REG_BUS(bus), .REG_RDATA(rdata), .HANDSET_PINS(pins),
        .VOICE_LINK_UP(link_up), .MSG_PENDING(msg_pending), .MSG_DONE(msg_done),
        .SIGNAL_STRENGTH_LEVEL(level), .DATA_SUSPEND(suspend), .LINK_REESTABLISH(reestablish),
        .TONE_TALK_READY(tone_ready), .TONE_INTERRUPT(tone_int), .VOICE_TX_PAUSE(tx_pause),
        .MSG_SEND(msg_send), .CALL_PRIORITY(prio), .CALL_TARGET(target), .VOLUME(volume),
        .LED_BAR(leds));

    vtpa_handset_model #(.HOLD_CYCLES(6)) hs (
        .clock(CLOCK), .talk_cmd(talk_cmd), .silence_cmd(silence_cmd), .pins(pins));

    // 40 MHz clock
    initial forever #12.5 CLOCK = ~CLOCK;

    // Cut a hang short; the whole sequence needs well under a thousand cycles
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
            n_errors++;
        end
    endtask

    // Bus cycles: strobe for one cycle, read data sampled in the cycle after
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLOCK);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge CLOCK);
        bus.wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
        @(posedge CLOCK);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge CLOCK);
        bus.rd <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask

    // Bounded wait; a one-cycle pulse is caught because it stands a whole cycle
    task automatic wait_high(ref logic sig, input int limit, input string what);
        for (int k = 0; k < limit && sig !== 1'b1; k++) begin
            @(posedge CLOCK);
            #1;
        end
        check({31'h0, sig}, 32'h1, what);
    endtask

    // LED bar blinks between two patterns; the lit one must show at least once
    task automatic led_scan(input logic [SLOT_COUNT-1:0] lit, input logic [SLOT_COUNT-1:0] dark, input string what);
        int hits;
        hits = 0;
        repeat (3 * FLASH) begin
            @(posedge CLOCK);
            #1;
            if (leds === lit) hits++;
            else check({24'h0, leds}, {24'h0, dark}, what);
        end
        check({31'h0, hits > 0}, 32'h1, what);
    endtask

    initial begin
        ids = '{default: IDENT_NONE};
        ids[1] = 24'h10_0001;
        ids[2] = 24'h20_0002;
        ids[4] = 24'h40_0004;
        walk = '{3'h2, 3'h4, 3'h1};
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        #1;
        check({26'h0, volume}, {26'h0, VOL_MEDIUM, VOL_MEDIUM}, "volume reset");
        check({31'h0, suspend}, 32'h0, "suspend at reset");
        bus_read(REG_VOLUME, {21'h0, VOL_MEDIUM, 5'h0, VOL_MEDIUM}, "volume register");
        bus_write(REG_VOLUME, 32'h0000_0502);
        #1;
        check({26'h0, volume}, {26'h0, 3'h5, 3'h2}, "volume reconfigured");
        bus_read(8'h10, 32'h0, "unmapped read");
        bus_write(REG_CTRL, 32'h0000_0105);
        #1;
        check({28'h0, prio}, 32'h5, "call priority");
        for (int i = 0; i < SLOT_COUNT; i++) bus_write(REG_SLOT_BASE + 8'(4 * i), {8'h0, ids[i]});
        bus_read(REG_SLOT_BASE + 8'h10, {8'h0, ids[4]}, "slot readback");
        bus_write(REG_TARGET, 32'h0000_0001);
        bus_write(REG_TARGET, 32'h0000_0003);
        bus_read(REG_TARGET, 32'h0000_1601, "empty slot refused");
        check({8'h0, target}, {8'h0, ids[1]}, "target follows index");
        check({24'h0, leds}, 32'h0000_0007, "normal level display");
        // Handset selection: first press shows, later presses advance and wrap
        hs.press_select();
        bus_read(REG_TARGET, 32'h0000_1601, "first press keeps target");
        led_scan(8'h02, 8'h00, "window flash");
        for (int i = 0; i < 3; i++) begin
            hs.press_select();
            bus_read(REG_TARGET, {16'h0, 16'h1600 | 16'(walk[i])}, "advance");
            check({8'h0, target}, {8'h0, ids[walk[i]]}, "advanced target live");
        end
        repeat (DISP + 20) @(posedge CLOCK);
        #1;
        check({24'h0, leds}, 32'h0000_0007, "window expired");
        // Talk cycle with message insertion and silence release
        talk_cmd <= 1'b1;
        wait_high(suspend, 10, "talk suspends data");
        led_scan(8'hFD, 8'hFF, "inverted call flash");
        @(posedge CLOCK);
        link_up <= 1'b1;
        wait_high(tone_ready, 5, "talk ready tone");
        bus_read(REG_STATUS, 32'h0000_0012, "status in talk");
        @(posedge CLOCK);
        msg_pending <= 1'b1;
        wait_high(msg_send, 5, "message inserted");
        check({30'h0, tx_pause, tone_int}, 32'h3, "voice paused with tones");
        @(posedge CLOCK);
        msg_pending <= 1'b0;
        msg_done <= 1'b1;
        @(posedge CLOCK);
        msg_done <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        check({30'h0, tx_pause, tone_int}, 32'h0, "voice resumed");
        talk_cmd <= 1'b0;
        silence_cmd <= 1'b1;
        repeat (SIL / 2) @(posedge CLOCK);
        #1;
        check({31'h0, suspend}, 32'h1, "still suspended in silence");
        wait_high(reestablish, SIL + 20, "link re-established");
        check({31'h0, suspend}, 32'h0, "data resumed");
        complete_run();
    end
endmodule
